// ---- design/lss_pkg.sv ----
// lss_pkg: constants, register map and types for the lmfc one-shot sync block
//
// Contract
// - Arm bit starts sync on next alignment edge
// - Subclass 1 uses reference edge, else internal
// - Done flag set, held until next request
// - Reference sampled by clock divided by four
// - Any periodicity; only rising edges matter
// - Zero skip: first edge aligns lmfc phase
// - Skip count edges ignored before sync; code skips in subclass 1 only
// - Subclass 1: later edges checked for drift
// - Window field bits 5..2, code 0 half clock
// - Arming drops sync requests, rotation restores
// - Any number of resyncs allowed
// - Subclass from bits 7..5, no subclass 2
// - Subclass 0 needs no reference activity
// - Release sync request at next lmfc edge
package lss_pkg;
  // ---------------------------------------------
  // register map
  // ---------------------------------------------
  localparam logic [11:0] ADDR_EDGE_SKIP_COUNT = 12'h036;
  localparam logic [11:0] ADDR_EDGE_ERROR_WINDOW = 12'h039;
  localparam logic [11:0] ADDR_SYNC_CONTROL = 12'h03a;
  localparam logic [11:0] ADDR_SYNC_ENABLE_CONFIG = 12'h03b;
  localparam logic [11:0] ADDR_REF_INPUT_CONFIG = 12'h084;
  localparam logic [11:0] ADDR_LINK_SUBCLASS_CONFIG = 12'h458;
  localparam logic [7:0] REG_RESET_VAL = 8'h00;
  // ---------------------------------------------
  // field positions
  // ---------------------------------------------
  localparam int ARM_BIT = 1;
  localparam int DONE_BIT = 4;
  localparam int SYNC_EN_BIT = 0;
  localparam int SOFT_RAMP_BIT = 1;
  localparam int COUPLING_BIT = 6;
  localparam int SUBCLASS_LSB = 5;
  localparam int SUBCLASS_MSB = 7;
  localparam int WIN_LSB = 2;
  localparam int WIN_MSB = 5;
  localparam logic [2:0] SUBCLASS_ONE = 3'h1;
  // ---------------------------------------------
  // timing
  // ---------------------------------------------
  localparam int SAMPLE_DIV = 4;
  localparam logic [1:0] DIV_LAST = 2'(SAMPLE_DIV - 1);
  localparam int LMFC_PERIOD = 64;
  localparam int LMFC_W = 7;
  localparam logic [LMFC_W-1:0] LMFC_LAST = LMFC_W'(LMFC_PERIOD - 1);
  localparam logic [LMFC_W-1:0] LMFC_HALF = LMFC_W'(LMFC_PERIOD / 2);
  localparam logic [LMFC_W-1:0] LMFC_ALIGN_LOAD = 7'h01;
  localparam int NUM_LINKS = 2;

  typedef enum logic [2:0] {
    SYNC_IDLE = 3'b001,
    SYNC_ARMED = 3'b010,
    SYNC_ROTATED = 3'b100
  } lss_sync_state_e;
endpackage

// ---- design/lss_ref_sampler.sv ----
// lss_ref_sampler: reference pin synchroniser, divided sampling tick and edge detect
`timescale 1ns/1ps
module lss_ref_sampler
  import lss_pkg::*;
(
  input wire logic clk, // device clock
  input wire logic sys_rst, // sync reset, active high
  input wire logic refPin, // raw reference input
  output logic sampleTick, // one pulse every four clocks
  output logic refEdge // sampled rising edge, one pulse
);
  logic refMeta_ff;
  logic refSync_ff;
  logic refSampled_ff;
  logic [1:0] divCnt_ff;

  // ---------------------------------------------
  // two-flop synchroniser, first stage read only by second
  // ---------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      refMeta_ff <= 1'b0;
      refSync_ff <= 1'b0;
    end else begin
      refMeta_ff <= refPin;
      refSync_ff <= refMeta_ff;
    end
  end

  // ---------------------------------------------
  // divide-by-four sampling
  // ---------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      divCnt_ff <= 2'h0;
      sampleTick <= 1'b0;
    end else begin
      divCnt_ff <= divCnt_ff + 2'h1;
      sampleTick <= (divCnt_ff == DIV_LAST);
    end
  end

  // pulses shorter than four clocks can fall between ticks and be missed
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      refSampled_ff <= 1'b0;
      refEdge <= 1'b0;
    end else begin
      if (divCnt_ff == DIV_LAST) begin
        refSampled_ff <= refSync_ff;
      end
      refEdge <= (divCnt_ff == DIV_LAST) && refSync_ff && !refSampled_ff;
    end
  end
endmodule

// ---- design/lss_reg_file.sv ----
// lss_reg_file: configuration registers with the documented register port
`timescale 1ns/1ps
module lss_reg_file
  import lss_pkg::*;
(
  input wire logic clk, // device clock
  input wire logic sys_rst, // sync reset, active high
  input wire logic regWrEn, // write strobe, one cycle
  input wire logic regRdEn, // read strobe, one cycle
  input wire logic [11:0] regAddr, // register address
  input wire logic [7:0] regWrData, // write data
  input wire logic rotationDone, // done status from sync logic
  output logic [7:0] regRdData, // read data, valid with regRdValid
  output logic regRdValid, // read answer, one cycle
  output logic [7:0] edgeSkipCount, // skip count register
  output logic [7:0] edgeErrorWindow, // drift window register
  output logic [7:0] syncControl, // stored control bits
  output logic [7:0] syncEnableConfig, // enable and soft ramp
  output logic [7:0] refInputConfig, // reference input setup
  output logic [7:0] linkSubclassConfig, // subclass field
  output logic armWrite // pulse: control written with arm set
);
  function automatic logic hit(input logic [11:0] a, input logic [11:0] reg_addr);
    hit = (a == reg_addr);
  endfunction

  // ---------------------------------------------
  // writes
  // ---------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      edgeSkipCount <= REG_RESET_VAL;
      edgeErrorWindow <= REG_RESET_VAL;
      syncControl <= REG_RESET_VAL;
      syncEnableConfig <= REG_RESET_VAL;
      refInputConfig <= REG_RESET_VAL;
      linkSubclassConfig <= REG_RESET_VAL;
      armWrite <= 1'b0;
    end else begin
      armWrite <= regWrEn && hit(regAddr, ADDR_SYNC_CONTROL) && regWrData[ARM_BIT];
      if (regWrEn) begin
        if (hit(regAddr, ADDR_EDGE_SKIP_COUNT)) edgeSkipCount <= regWrData;
        if (hit(regAddr, ADDR_EDGE_ERROR_WINDOW)) edgeErrorWindow <= regWrData;
        if (hit(regAddr, ADDR_SYNC_CONTROL)) syncControl <= regWrData;
        if (hit(regAddr, ADDR_SYNC_ENABLE_CONFIG)) syncEnableConfig <= regWrData;
        if (hit(regAddr, ADDR_REF_INPUT_CONFIG)) refInputConfig <= regWrData;
        if (hit(regAddr, ADDR_LINK_SUBCLASS_CONFIG)) linkSubclassConfig <= regWrData;
      end
    end
  end

  // ---------------------------------------------
  // reads; unmapped addresses return zero
  // ---------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      regRdData <= 8'h00;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRdEn;
      if (regRdEn) begin
        case (regAddr)
          ADDR_EDGE_SKIP_COUNT: regRdData <= edgeSkipCount;
          ADDR_EDGE_ERROR_WINDOW: regRdData <= edgeErrorWindow;
          ADDR_SYNC_CONTROL: begin
            regRdData <= syncControl;
            regRdData[DONE_BIT] <= rotationDone;
          end
          ADDR_SYNC_ENABLE_CONFIG: regRdData <= syncEnableConfig;
          ADDR_REF_INPUT_CONFIG: regRdData <= refInputConfig;
          ADDR_LINK_SUBCLASS_CONFIG: regRdData <= linkSubclassConfig;
          default: regRdData <= 8'h00;
        endcase
      end
    end
  end
endmodule

// ---- design/lss_sync_top.sv ----
// lss_sync_top: one-shot lmfc alignment, edge skipping, drift watch and sync request control
`timescale 1ns/1ps
module lss_sync_top
  import lss_pkg::*;
(
  input wire logic clk, // device clock
  input wire logic sys_rst, // sync reset, active high
  input wire logic regWrEn, // register write strobe
  input wire logic regRdEn, // register read strobe
  input wire logic [11:0] regAddr, // register address
  input wire logic [7:0] regWrData, // register write data
  output logic [7:0] regRdData, // register read data
  output logic regRdValid, // read answer pulse
  input wire logic refPin, // reference input pin
  input wire logic [NUM_LINKS-1:0] commaLock, // four commas seen per link
  input wire logic driftIrqClear, // clear pulse for drift flag
  output logic [NUM_LINKS-1:0] linkSyncRequestOutN, // low requests resync
  output logic refEdgeDriftIrq, // sticky drift flag
  output logic syncRotationDone, // alignment done flag
  output logic lmfcPulse, // internal lmfc edge
  output logic datapathSoftRamp, // ramp request around sync
  output logic refInputCouplingSel // 1 dc-coupled, 0 ac-coupled
);
  // ---------------------------------------------
  // declarations
  // ---------------------------------------------
  logic sampleTick;
  logic refEdge;
  logic [7:0] edgeSkipCount;
  logic [7:0] edgeErrorWindow;
  logic [7:0] syncControl;
  logic [7:0] syncEnableConfig;
  logic [7:0] refInputConfig;
  logic [7:0] linkSubclassConfig;
  logic armWrite;
  logic subclassOne;
  logic alignEdge;
  logic syncEnabled;
  logic rotateNow;
  logic driftSet;
  logic [LMFC_W-1:0] phaseDev;
  logic [LMFC_W-1:0] windowClocks;
  lss_sync_state_e state_ff;
  lss_sync_state_e nxt_state;
  logic [7:0] skipLeft_ff;
  logic [LMFC_W-1:0] lmfcCnt_ff;

  function automatic logic [LMFC_W-1:0] phase_distance(input logic [LMFC_W-1:0] ph);
    phase_distance = (ph < LMFC_HALF) ? ph : LMFC_W'(LMFC_PERIOD - int'(ph));
  endfunction

  // ---------------------------------------------
  // submodules
  // ---------------------------------------------
  lss_ref_sampler uSampler (
    .clk(clk),
    .sys_rst(sys_rst),
    .refPin(refPin),
    .sampleTick(sampleTick),
    .refEdge(refEdge)
  );

  lss_reg_file uRegs (
    .clk(clk),
    .sys_rst(sys_rst),
    .regWrEn(regWrEn),
    .regRdEn(regRdEn),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .rotationDone(syncRotationDone),
    .regRdData(regRdData),
    .regRdValid(regRdValid),
    .edgeSkipCount(edgeSkipCount),
    .edgeErrorWindow(edgeErrorWindow),
    .syncControl(syncControl),
    .syncEnableConfig(syncEnableConfig),
    .refInputConfig(refInputConfig),
    .linkSubclassConfig(linkSubclassConfig),
    .armWrite(armWrite)
  );

  // ---------------------------------------------
  // alignment edge selection
  // ---------------------------------------------
  // subclass 2 and reserved codes fall back to the internal edge
  assign subclassOne = (linkSubclassConfig[SUBCLASS_MSB:SUBCLASS_LSB] == SUBCLASS_ONE);
  assign alignEdge = subclassOne ? refEdge : sampleTick;
  assign syncEnabled = syncEnableConfig[SYNC_EN_BIT];
  assign rotateNow = (state_ff == SYNC_ARMED) && alignEdge && (skipLeft_ff == 8'h00);

  // ---------------------------------------------
  // sync state machine
  // ---------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SYNC_IDLE: begin
        if (armWrite && syncEnabled) nxt_state = SYNC_ARMED;
      end
      SYNC_ARMED: begin
        if (!syncControl[ARM_BIT]) nxt_state = SYNC_IDLE;
        else if (rotateNow) nxt_state = SYNC_ROTATED;
      end
      SYNC_ROTATED: begin
        if (armWrite && syncEnabled) nxt_state = SYNC_ARMED;
        else if (!syncControl[ARM_BIT]) nxt_state = SYNC_IDLE;
      end
      default: nxt_state = SYNC_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) state_ff <= SYNC_IDLE;
    else state_ff <= nxt_state;
  end

  // ---------------------------------------------
  // edge skipping
  // ---------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      skipLeft_ff <= 8'h00;
    end else if (armWrite) begin
      skipLeft_ff <= subclassOne ? edgeSkipCount : 8'h00;
    end else if (state_ff == SYNC_ARMED && alignEdge && skipLeft_ff != 8'h00) begin
      skipLeft_ff <= skipLeft_ff - 8'h01;
    end
  end

  // ---------------------------------------------
  // done flag
  // ---------------------------------------------
  always_ff @(posedge clk) begin
    // set wins over a re-arm landing in the same cycle
    if (sys_rst) syncRotationDone <= 1'b0;
    else if (rotateNow) syncRotationDone <= 1'b1;
    else if (armWrite && syncEnabled) syncRotationDone <= 1'b0;
  end

  // ---------------------------------------------
  // internal lmfc
  // ---------------------------------------------
  // loaded with one so that the aligning edge's own cycle counts as phase zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lmfcCnt_ff <= '0;
      lmfcPulse <= 1'b0;
    end else begin
      if (rotateNow) lmfcCnt_ff <= LMFC_ALIGN_LOAD;
      else if (lmfcCnt_ff == LMFC_LAST) lmfcCnt_ff <= '0;
      else lmfcCnt_ff <= lmfcCnt_ff + LMFC_W'(1);
      lmfcPulse <= rotateNow || (lmfcCnt_ff == LMFC_LAST);
    end
  end

  // ---------------------------------------------
  // drift watch
  // ---------------------------------------------
  // window resolution is four clocks since edges only land on sample ticks
  assign windowClocks = LMFC_W'({edgeErrorWindow[WIN_MSB:WIN_LSB], 2'h0});
  assign phaseDev = phase_distance(lmfcCnt_ff);
  assign driftSet = subclassOne && refEdge && (state_ff != SYNC_ARMED) && syncRotationDone
    && (phaseDev > windowClocks);

  always_ff @(posedge clk) begin
    if (sys_rst) refEdgeDriftIrq <= 1'b0;
    else if (driftSet) refEdgeDriftIrq <= 1'b1;
    else if (driftIrqClear) refEdgeDriftIrq <= 1'b0;
  end

  // ---------------------------------------------
  // link sync requests
  // ---------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      linkSyncRequestOutN <= '0;
    end else begin
      for (int i = 0; i < NUM_LINKS; i++) begin
        if (armWrite && syncEnabled) linkSyncRequestOutN[i] <= 1'b0;
        else if (syncRotationDone && commaLock[i] && lmfcCnt_ff == LMFC_LAST) begin
          linkSyncRequestOutN[i] <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------
  // soft ramp and coupling outputs
  // ---------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      datapathSoftRamp <= 1'b0;
      refInputCouplingSel <= 1'b0;
    end else begin
      datapathSoftRamp <= syncEnableConfig[SOFT_RAMP_BIT] && (state_ff == SYNC_ARMED);
      refInputCouplingSel <= refInputConfig[COUPLING_BIT];
    end
  end

  // ---------------------------------------------
  // assertions
  // ---------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_arm_enters_armed: assert property (armWrite && syncEnabled |=> state_ff == SYNC_ARMED)
    else $error("arm write did not arm the sync");
  a_idle_no_rotate: assert property (state_ff == SYNC_IDLE |=> !$rose(syncRotationDone))
    else $error("rotation without arming");
  a_subclass_edge: assert property (state_ff == SYNC_ARMED && subclassOne && skipLeft_ff == 8'h00
    && refEdge && syncControl[ARM_BIT] |=> syncRotationDone && lmfcCnt_ff == LMFC_ALIGN_LOAD)
    else $error("reference edge did not align lmfc");
  a_done_holds: assert property (syncRotationDone && !(armWrite && syncEnabled) |=> syncRotationDone)
    else $error("done flag dropped without new request");
  a_skip_blocks: assert property (state_ff == SYNC_ARMED && skipLeft_ff != 8'h00 |=> !$rose(syncRotationDone))
    else $error("sync taken while edges still to skip");
  a_tick_period: assert property (sampleTick |=> !sampleTick [*3] ##1 sampleTick)
    else $error("sampling tick not every four clocks");
  a_drift_sets: assert property (driftSet |=> refEdgeDriftIrq)
    else $error("drift not flagged");
  a_drift_sticky: assert property (refEdgeDriftIrq && !driftIrqClear |=> refEdgeDriftIrq)
    else $error("drift flag cleared by itself");
  a_zero_window: assert property (refEdge && subclassOne && syncRotationDone && state_ff != SYNC_ARMED
    && edgeErrorWindow[WIN_MSB:WIN_LSB] == 4'h0 && lmfcCnt_ff != '0 |=> refEdgeDriftIrq)
    else $error("half-clock window missed an offset edge");
  a_arm_drops_link: assert property (armWrite && syncEnabled |=> linkSyncRequestOutN == '0)
    else $error("sync request not asserted on arm");
  a_release_on_lmfc: assert property ($rose(linkSyncRequestOutN[0]) |-> $past(lmfcCnt_ff) == LMFC_LAST
    && $past(commaLock[0]) && $past(syncRotationDone))
    else $error("link released off the lmfc edge");

  c_rotation: cover property (state_ff == SYNC_ARMED ##[1:300] state_ff == SYNC_ROTATED);
  c_skip_three: cover property (armWrite && edgeSkipCount == 8'h03 ##[1:1000] syncRotationDone);
  c_drift: cover property ($rose(refEdgeDriftIrq));
  c_link_up: cover property ($rose(linkSyncRequestOutN[1]));
  c_zero_window: cover property ($rose(refEdgeDriftIrq) && edgeErrorWindow[WIN_MSB:WIN_LSB] == 4'h0);
endmodule

// ---- bench/lss_ref_source.sv ----
// lss_ref_source: model of the reference pulse source and the link transmitter
`timescale 1ns/1ps
module lss_ref_source (
  input wire logic clk, // device clock
  input wire logic sys_rst, // sync reset, active high
  input wire logic fire, // start a pulse train
  input wire logic [7:0] count, // pulses in the train
  input wire logic [7:0] gap, // clocks between rising edges
  input wire logic commaEn, // transmitter sends commas
  output logic refPin, // reference pulse output
  output logic busy, // train in progress
  output logic [1:0] commaLock // per link comma lock
);
  logic [7:0] leftCnt_ff;
  logic [7:0] phase_ff;

  assign busy = (leftCnt_ff != 8'h00);

  // ---------------------------------------------
  // pulse train
  // ---------------------------------------------
  // pulses stay high eight clocks so the divided sampler cannot miss them
  always @(posedge clk) begin
    if (sys_rst) begin
      leftCnt_ff <= 8'h00;
      phase_ff <= 8'h00;
      refPin <= 1'b0;
    end else if (fire) begin
      leftCnt_ff <= count;
      phase_ff <= 8'h00;
    end else if (busy) begin
      refPin <= (phase_ff < 8'h08);
      if (phase_ff == gap - 8'h01) begin
        phase_ff <= 8'h00;
        leftCnt_ff <= leftCnt_ff - 8'h01;
      end else begin
        phase_ff <= phase_ff + 8'h01;
      end
    end else begin
      refPin <= 1'b0;
    end
  end

  // ---------------------------------------------
  // comma lock, second link one clock late
  // ---------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      commaLock <= 2'h0;
    end else begin
      commaLock <= {commaLock[0], commaEn};
    end
  end
endmodule

// ---- bench/lss_sync_top_tb.sv ----
// lss_sync_top_tb: register-level tests of one-shot sync, skipping, drift and link requests
`timescale 1ns/1ps
module lss_sync_top_tb;
  import lss_pkg::*;
  logic clk, sys_rst, regWrEn, regRdEn, regRdValid, refPin, driftIrqClear;
  logic [11:0] regAddr;
  logic [7:0] regWrData, regRdData, count, gap, d;
  logic [1:0] commaLock, linkSyncRequestOutN;
  logic refEdgeDriftIrq, syncRotationDone, lmfcPulse, datapathSoftRamp, refInputCouplingSel;
  logic fire, commaEn, busy;
  int n_mismatch = 0;
  int checked = 0;
  logic [11:0] rstAddr [7] = '{ADDR_EDGE_SKIP_COUNT, ADDR_EDGE_ERROR_WINDOW, ADDR_SYNC_CONTROL,
    ADDR_SYNC_ENABLE_CONFIG, ADDR_REF_INPUT_CONFIG, ADDR_LINK_SUBCLASS_CONFIG, 12'h100};
  logic [11:0] rbAddr [5] = '{ADDR_EDGE_SKIP_COUNT, ADDR_EDGE_ERROR_WINDOW, ADDR_REF_INPUT_CONFIG,
    ADDR_LINK_SUBCLASS_CONFIG, 12'h037};
  logic [7:0] rbData [5] = '{8'h03, 8'h04, 8'h40, 8'h20, 8'hff};
  logic [7:0] rbExp [5] = '{8'h03, 8'h04, 8'h40, 8'h20, 8'h00};

  lss_sync_top lss_sync_top_inst (.clk(clk), .sys_rst(sys_rst), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
    .refPin(refPin), .commaLock(commaLock), .driftIrqClear(driftIrqClear),
    .linkSyncRequestOutN(linkSyncRequestOutN), .refEdgeDriftIrq(refEdgeDriftIrq),
    .syncRotationDone(syncRotationDone), .lmfcPulse(lmfcPulse), .datapathSoftRamp(datapathSoftRamp),
    .refInputCouplingSel(refInputCouplingSel));

  lss_ref_source lss_ref_source_inst (.clk(clk), .sys_rst(sys_rst), .fire(fire), .count(count),
    .gap(gap), .commaEn(commaEn), .refPin(refPin), .busy(busy), .commaLock(commaLock));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  task automatic print_verdict();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // all drives land 1 ns after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // idle cycle after each access keeps strobes from toggling twice in one step
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    regWrEn = 1'b1;
    regAddr = a;
    regWrData = v;
    tick(1);
    regWrEn = 1'b0;
    tick(1);
  endtask

  task automatic rd(input logic [11:0] a, output logic [7:0] v);
    regRdEn = 1'b1;
    regAddr = a;
    tick(1);
    regRdEn = 1'b0;
    chk("read valid", 8'h01, {7'h00, regRdValid});
    v = regRdData;
    tick(1);
  endtask

  task automatic pulses(input logic [7:0] n, input logic [7:0] g);
    fire = 1'b1;
    count = n;
    gap = g;
    tick(1);
    fire = 1'b0;
    tick(1);
  endtask

  task automatic arm();
    wr(ADDR_SYNC_CONTROL, 8'h00);
    wr(ADDR_SYNC_CONTROL, 8'h02);
  endtask

  // which: 0 done, 1 links released, 2 source idle, 3 lmfc pulse, 4 drift flag
  task automatic waitFor(input int which, input int bound, input string what);
    int i;
    for (i = 0; i < bound; i++) begin
      if (which == 0 && syncRotationDone === 1'b1) break;
      if (which == 1 && linkSyncRequestOutN === 2'h3) break;
      if (which == 2 && busy === 1'b0) break;
      if (which == 3 && lmfcPulse === 1'b1) break;
      if (which == 4 && refEdgeDriftIrq === 1'b1) break;
      tick(1);
    end
    checked++;
    if (i == bound) begin
      n_mismatch++;
      $display("ERROR %s expected within %0d cycles seen timeout", what, bound);
      print_verdict();
    end
  endtask

  initial begin
    #500000;
    n_mismatch++;
    print_verdict();
  end

  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    sys_rst = 1'b1;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 12'h000;
    regWrData = 8'h00;
    driftIrqClear = 1'b0;
    fire = 1'b0;
    count = 8'h00;
    gap = 8'h10;
    commaEn = 1'b0;
    tick(8);
    sys_rst = 1'b0;
    chk("link requests after reset", 8'h00, {6'h00, linkSyncRequestOutN});
    chk("done after reset", 8'h00, {7'h00, syncRotationDone});
    foreach (rstAddr[k]) begin
      rd(rstAddr[k], d);
      chk("reset value", REG_RESET_VAL, d);
    end
    foreach (rbAddr[k]) begin
      wr(rbAddr[k], rbData[k]);
    end
    foreach (rbAddr[k]) begin
      rd(rbAddr[k], d);
      chk("readback", rbExp[k], d);
    end
    chk("coupling select", 8'h01, {7'h00, refInputCouplingSel});
    // subclass 1 now; edges before any arm must be ignored
    pulses(8'h01, 8'h10);
    waitFor(2, 100, "source idle");
    tick(10);
    chk("drift flag idle", 8'h00, {7'h00, refEdgeDriftIrq});
    // arming while the circuitry is disabled is refused
    arm();
    pulses(8'h04, 8'h20);
    waitFor(2, 300, "source idle");
    tick(10);
    chk("done while disabled", 8'h00, {7'h00, syncRotationDone});
    // subclass 1 with three skipped edges and soft ramp
    wr(ADDR_SYNC_ENABLE_CONFIG, 8'hf3);
    arm();
    // ramp follows the armed state one clock later
    tick(1);
    chk("soft ramp", 8'h01, {7'h00, datapathSoftRamp});
    chk("requests on arm", 8'h00, {6'h00, linkSyncRequestOutN});
    pulses(8'h03, 8'h20);
    waitFor(2, 300, "source idle");
    tick(10);
    chk("done after skipped edges", 8'h00, {7'h00, syncRotationDone});
    pulses(8'h02, 8'h40);
    waitFor(0, 40, "done on fourth edge");
    rd(ADDR_SYNC_CONTROL, d);
    chk("done bit", 8'h10, d & 8'h10);
    waitFor(2, 200, "source idle");
    tick(12);
    chk("drift flag aligned edge", 8'h00, {7'h00, refEdgeDriftIrq});
    // an edge twenty-eight clocks past the lmfc edge is far outside a four-clock window
    waitFor(3, 70, "lmfc pulse");
    tick(20);
    pulses(8'h01, 8'h10);
    waitFor(4, 30, "drift flag");
    tick(10);
    chk("drift flag sticky", 8'h01, {7'h00, refEdgeDriftIrq});
    driftIrqClear = 1'b1;
    tick(1);
    driftIrqClear = 1'b0;
    tick(1);
    chk("drift flag cleared", 8'h00, {7'h00, refEdgeDriftIrq});
    // edge lands four clocks past the lmfc edge: inside the four-clock window only
    waitFor(3, 70, "lmfc pulse");
    tick(61);
    pulses(8'h01, 8'h10);
    tick(12);
    chk("drift flag on window edge", 8'h00, {7'h00, refEdgeDriftIrq});
    wr(ADDR_EDGE_ERROR_WINDOW, 8'h00);
    waitFor(3, 70, "lmfc pulse");
    tick(61);
    pulses(8'h01, 8'h10);
    waitFor(4, 20, "drift flag half-clock window");
    // subclass 0: internal alignment edge, reference left quiet
    wr(ADDR_LINK_SUBCLASS_CONFIG, 8'h00);
    arm();
    chk("done cleared on arm", 8'h00, {7'h00, syncRotationDone});
    waitFor(0, 12, "done subclass 0");
    tick(140);
    chk("requests without commas", 8'h00, {6'h00, linkSyncRequestOutN});
    commaEn = 1'b1;
    waitFor(1, 70, "links released");
    // resync drops and restores the links again
    wr(ADDR_SYNC_ENABLE_CONFIG, 8'hf1);
    arm();
    chk("requests on resync", 8'h00, {6'h00, linkSyncRequestOutN});
    chk("done cleared on resync", 8'h00, {7'h00, syncRotationDone});
    waitFor(0, 12, "done resync");
    waitFor(1, 70, "links restored");
    wr(ADDR_REF_INPUT_CONFIG, 8'h00);
    chk("coupling select ac", 8'h00, {7'h00, refInputCouplingSel});
    print_verdict();
  end
endmodule
